/* core/uwc_pkg.sv */
// Constants, types and the register map of the upper-level walk cache.
// Assumes one clock domain shared with the page-walk engine.
//
// Summary of operation
// - Nested level-4 entry stores the second-stage-translated table address.
// - Nested level-4 write is AND of level-5/4 writes and second-stage writes.
// - Nested level-4 user flag is AND of level-5/4 user flags.
// - Nested exec-disable ORs first-stage flags with second-stage execute term.
// - A lookup hit returns the cached entry instead of reading memory.
// - First-stage entries need present set and reserved clear everywhere.
// - Nested entries need second-stage read permission for each contributor.
// - Second-stage entries need read or write set and reserved clear.
// - Second-stage creation checks apply only while caching mode reads zero.
// - Accessed flags are written in memory before a first-stage entry.
// - Extended accessed flags are also written when that mode is enabled.
// - Under nesting, flag writes need second-stage write permission.
// - Entries may be created without any complete lower translation.
// - Entries stay unchanged when memory tables change later.
// - Level-3 first-stage or nested tag is 18 or 27 bits from N:30.
// - N is bit 56 with five levels and bit 47 with four.
// - First-stage level-3 combines flags over levels; page leaves not cached.
// - Second-stage level-3 tag uses bits max_guest_addr_width down to 30.
// - Second-stage level-3 ANDs read, write, execute; page leaves not cached.
// - Nested level-3 stores translated address with combined write and exec.
// - Level-4 first-stage or nested tag is 9 or 18 bits from N:39.
// - Every entry is also tagged with domain and address-space identifiers.
// - Any entry may be dropped at any time.

package uwc_pkg;

   // ==========================================================
   // Sizes
   localparam int UWC_ENTRIES = 16;
   localparam int UWC_IDX_W = 4;
   localparam int UWC_VA_W = 57;
   localparam int UWC_TBL_W = 40;
   localparam int UWC_DID_W = 16;
   localparam int UWC_PASID_W = 20;
   localparam int UWC_TAG_W = 27;

   // ==========================================================
   // Tag geometry
   localparam logic [6:0] UWC_L3_SHIFT = 7'h1E;
   localparam logic [6:0] UWC_L4_SHIFT = 7'h27;
   localparam logic [5:0] UWC_TOP_5LVL = 6'h38;
   localparam logic [5:0] UWC_TOP_4LVL = 6'h2F;

   // ==========================================================
   // Register map
   localparam logic [7:0] UWC_REG_CFG = 8'h00;
   localparam logic [7:0] UWC_REG_STAT = 8'h04;
   localparam logic [7:0] UWC_REG_HITS = 8'h08;
   localparam int UWC_CFG_FIVE = 0;
   localparam int UWC_CFG_XDEN = 1;
   localparam int UWC_CFG_SSXEN = 2;
   localparam int UWC_CFG_EAEN = 3;
   localparam int UWC_CFG_CM = 4;
   localparam int UWC_CFG_MAX_GUEST_ADDR_WIDTH_LO = 8;
   localparam logic [13:0] UWC_CFG_RST = 14'h2F00;
   localparam int UWC_STAT_ST_LO = 16;

   typedef enum logic [1:0] {
      UWC_XL_FIRST = 2'h0,
      UWC_XL_SECOND = 2'h1,
      UWC_XL_NESTED = 2'h2
   } uwc_xlat_t;

   typedef enum logic [2:0] {
      UWC_ST_IDLE = 3'h1,
      UWC_ST_UPD = 3'h2,
      UWC_ST_WAIT = 3'h4
   } uwc_state_t;

   typedef struct packed {
      logic valid;
      logic lvl4;
      logic [1:0] xlat;
      logic [26:0] tag;
      logic [15:0] did;
      logic pasidVld;
      logic [19:0] pasid;
      logic [39:0] tbl;
      logic rd;
      logic wr;
      logic us;
      logic xd;
   } uwc_entry_t;

endpackage

/* core/uwc_walk_cache.sv */
// Level-4 and level-3 paging-structure cache for the page-walk engine.
// Assumes the walk engine, memory port and register master share core_clk;
// the walk engine supplies raw entry fields and second-stage results.
//
// The implementer's own choices: the placing of the registers and the address-and-strobe port.

`timescale 1ns/1ps
`default_nettype none

module uwc_walk_cache
   import uwc_pkg::*;
(
   input wire logic core_clk,
   input wire logic nrst,
   // Register port
   input wire logic [7:0] regAddr,
   input wire logic [31:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   output logic [31:0] regRdData_r,
   // Lookup
   input wire logic lkReq,
   input wire logic lkLvl4,
   input wire logic [1:0] lkXlat,
   input wire logic [56:0] lkAddr,
   input wire logic [15:0] lkDid,
   input wire logic lkPasidVld,
   input wire logic [19:0] lkPasid,
   output logic lkRsp_r,
   output logic lkHit_r,
   output logic [39:0] lkTable_r,
   output logic lkRd_r,
   output logic lkWr_r,
   output logic lkUs_r,
   output logic lkXd_r,
   // Fill; vectors index 0 = level 3, 1 = level 4, 2 = level 5
   input wire logic fillReq,
   input wire logic fillLvl4,
   input wire logic [1:0] fillXlat,
   input wire logic [56:0] fillAddr,
   input wire logic [15:0] fillDid,
   input wire logic fillPasidVld,
   input wire logic [19:0] fillPasid,
   input wire logic [39:0] fillTable,
   input wire logic fillLeaf,
   input wire logic [2:0] entPresent,
   input wire logic [2:0] entRsvdOk,
   input wire logic [2:0] entR,
   input wire logic [2:0] entW,
   input wire logic [2:0] entU,
   input wire logic [2:0] entX,
   input wire logic [2:0] entAcc,
   input wire logic [2:0] entExtAcc,
   input wire logic [2:0] nestRd,
   input wire logic [2:0] nestWr,
   input wire logic [2:0] nestX,
   input wire logic [2:0] nestLocWr,
   output logic fillReady_r,
   output logic fillDone_r,
   output logic fillMade_r,
   // Accessed-flag writes to table memory
   output logic memWrReq_r,
   output logic [1:0] memWrLvl_r,
   output logic memWrEa_r,
   input wire logic memWrAck,
   // Invalidation
   input wire logic invReq,
   input wire logic invGlobal,
   input wire logic [15:0] invDid,
   output logic invAck_r
);

   // ==========================================================
   // Reset release
   logic rstSync1_r;
   logic rstSync2_r;
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         rstSync1_r <= 1'b0;
         rstSync2_r <= 1'b0;
      end else begin
         rstSync1_r <= 1'b1;
         rstSync2_r <= rstSync1_r;
      end
   end
   wire logic rstN = rstSync2_r;

   // ==========================================================
   // State
   uwc_entry_t ent_r [UWC_ENTRIES];
   uwc_entry_t ent_nxt [UWC_ENTRIES];
   logic [13:0] cfg_r, cfg_nxt;
   logic [15:0] hits_r, hits_nxt;
   logic [UWC_IDX_W-1:0] rr_r, rr_nxt;
   uwc_state_t st_r, st_nxt;
   uwc_entry_t pendEnt_r, pendEnt_nxt;
   logic [2:0] pend_r, pend_nxt;
   logic [2:0] pendEa_r, pendEa_nxt;
   logic [31:0] rdData_nxt;
   logic lkRsp_nxt, lkHit_nxt, lkRd_nxt, lkWr_nxt, lkUs_nxt, lkXd_nxt;
   logic [39:0] lkTable_nxt;
   logic fillReady_nxt, fillDone_nxt, fillMade_nxt;
   logic memWrReq_nxt, memWrEa_nxt, invAck_nxt;
   logic [1:0] memWrLvl_nxt;

   wire logic five = cfg_r[UWC_CFG_FIVE];
   wire logic xdEn = cfg_r[UWC_CFG_XDEN];
   wire logic ssxEn = cfg_r[UWC_CFG_SSXEN];
   wire logic eaEn = cfg_r[UWC_CFG_EAEN];
   wire logic cmCap = cfg_r[UWC_CFG_CM];
   wire logic [5:0] mgawTop = cfg_r[UWC_CFG_MAX_GUEST_ADDR_WIDTH_LO +: 6];

   // Tag is the input address from the top bit down to the level's shift,
   // zero-extended so narrower tags still compare exactly.
   function automatic logic [26:0] tagOf(input logic [56:0] a,
                                         input logic l4,
                                         input logic ss);
      logic [5:0] top;
      logic [56:0] msk;
      logic [56:0] sh;
      top = ss ? mgawTop : (five ? UWC_TOP_5LVL : UWC_TOP_4LVL);
      msk = ~({57{1'b1}} << ({1'b0, top} + 7'h01));
      sh = (a & msk) >> (l4 ? UWC_L4_SHIFT : UWC_L3_SHIFT);
      return sh[26:0];
   endfunction

   // ==========================================================
   // Lookup match
   logic [UWC_ENTRIES-1:0] lkMatch;
   logic [UWC_ENTRIES-1:0] invMatch;
   logic [26:0] lkTag;
   always_comb lkTag = tagOf(lkAddr, lkLvl4, lkXlat == UWC_XL_SECOND);

   genvar gi;
   generate
      for (gi = 0; gi < UWC_ENTRIES; gi++) begin : gMatch
         assign lkMatch[gi] = ent_r[gi].valid && ent_r[gi].lvl4 == lkLvl4 &&
                              ent_r[gi].xlat == lkXlat &&
                              ent_r[gi].tag == lkTag &&
                              ent_r[gi].did == lkDid &&
                              ent_r[gi].pasidVld == lkPasidVld &&
                              (!lkPasidVld || ent_r[gi].pasid == lkPasid);
         assign invMatch[gi] = invGlobal || ent_r[gi].did == invDid;
      end
   endgenerate

   // ==========================================================
   // Fill evaluation: creation checks and combined flags
   logic [2:0] contrib;
   logic [1:0] tgt;
   logic isSs, isNest, fillOk;
   logic [2:0] accNeed, eaNeed;
   uwc_entry_t newEnt;

   always_comb begin
      contrib = {five, 1'b1, ~fillLvl4};
      tgt = fillLvl4 ? 2'h1 : 2'h0;
      isSs = fillXlat == UWC_XL_SECOND;
      isNest = fillXlat == UWC_XL_NESTED;
      fillOk = !fillLeaf;
      if (isSs) begin
         if (!cmCap) begin
            fillOk = fillOk && &(((entR | entW) & entRsvdOk) | ~contrib);
         end
      end else begin
         fillOk = fillOk && &((entPresent & entRsvdOk) | ~contrib);
         if (isNest) begin
            fillOk = fillOk && &(nestRd | ~contrib);
         end
      end
      accNeed = isSs ? 3'h0 : contrib & ~entAcc;
      eaNeed = (isSs || !eaEn) ? 3'h0 : contrib & ~entExtAcc;
      // A flag that cannot be written under nesting blocks the entry
      if (isNest && |((accNeed | eaNeed) & ~nestLocWr)) begin
         fillOk = 1'b0;
      end
      newEnt = '0;
      newEnt.valid = 1'b1;
      newEnt.lvl4 = fillLvl4;
      newEnt.xlat = fillXlat;
      newEnt.tag = tagOf(fillAddr, fillLvl4, isSs);
      newEnt.did = fillDid;
      newEnt.pasidVld = fillPasidVld;
      newEnt.pasid = fillPasid;
      newEnt.tbl = fillTable;
      if (isSs) begin
         newEnt.rd = &(entR | ~contrib);
         newEnt.wr = &(entW | ~contrib);
         newEnt.us = 1'b1;
         newEnt.xd = ssxEn && !(&(entX | ~contrib));
      end else begin
         newEnt.rd = 1'b1;
         newEnt.wr = &(entW | ~contrib);
         newEnt.us = &(entU | ~contrib);
         newEnt.xd = xdEn && |(entX & contrib);
         if (isNest) begin
            newEnt.wr = newEnt.wr && nestWr[tgt];
            newEnt.xd = newEnt.xd || (ssxEn && !nestX[tgt]);
         end
      end
   end

   // ==========================================================
   // Victim choice: first free slot, else round robin
   logic [UWC_IDX_W-1:0] victim;
   logic freeFound;
   always_comb begin
      victim = rr_r;
      freeFound = 1'b0;
      for (int i = 0; i < UWC_ENTRIES; i++) begin
         if (!freeFound && !ent_r[i].valid) begin
            victim = UWC_IDX_W'(i);
            freeFound = 1'b1;
         end
      end
   end

   // ==========================================================
   // Next-state logic
   logic fillTake, invTake, commit;
   logic [1:0] upLvl;
   always_comb begin
      ent_nxt = ent_r;
      cfg_nxt = cfg_r;
      hits_nxt = hits_r;
      rr_nxt = rr_r;
      st_nxt = st_r;
      pendEnt_nxt = pendEnt_r;
      pend_nxt = pend_r;
      pendEa_nxt = pendEa_r;
      rdData_nxt = 32'h0;
      lkRsp_nxt = lkReq;
      lkHit_nxt = 1'b0;
      lkTable_nxt = 40'h0;
      lkRd_nxt = 1'b0;
      lkWr_nxt = 1'b0;
      lkUs_nxt = 1'b0;
      lkXd_nxt = 1'b0;
      fillDone_nxt = 1'b0;
      fillMade_nxt = 1'b0;
      memWrReq_nxt = 1'b0;
      memWrLvl_nxt = memWrLvl_r;
      memWrEa_nxt = memWrEa_r;
      invAck_nxt = 1'b0;
      commit = 1'b0;
      upLvl = 2'h0;

      // Lookup answers from the array; memory tables are never re-read
      if (lkReq) begin
         for (int i = UWC_ENTRIES - 1; i >= 0; i--) begin
            if (lkMatch[i]) begin
               lkHit_nxt = 1'b1;
               lkTable_nxt = ent_r[i].tbl;
               lkRd_nxt = ent_r[i].rd;
               lkWr_nxt = ent_r[i].wr;
               lkUs_nxt = ent_r[i].us;
               lkXd_nxt = ent_r[i].xd;
            end
         end
         if (|lkMatch) begin
            hits_nxt = hits_r + 16'h0001;
         end
      end

      fillTake = st_r == UWC_ST_IDLE && fillReady_r && fillReq;
      // Invalidation waits out any fill so no stale entry lands after it
      invTake = st_r == UWC_ST_IDLE && !fillTake && invReq && !invAck_r;

      case (st_r)
         UWC_ST_IDLE: begin
            if (fillTake) begin
               if (!fillOk) begin
                  fillDone_nxt = 1'b1;
               end else if ((accNeed | eaNeed) == 3'h0) begin
                  pendEnt_nxt = newEnt;
                  commit = 1'b1;
               end else begin
                  pendEnt_nxt = newEnt;
                  pend_nxt = accNeed | eaNeed;
                  pendEa_nxt = eaNeed;
                  st_nxt = UWC_ST_UPD;
               end
            end
         end
         UWC_ST_UPD: begin
            // Walk order: upper level written first
            if (pend_r[2]) begin
               upLvl = 2'h2;
            end else if (pend_r[1]) begin
               upLvl = 2'h1;
            end else begin
               upLvl = 2'h0;
            end
            memWrReq_nxt = 1'b1;
            memWrLvl_nxt = upLvl;
            memWrEa_nxt = pendEa_r[upLvl];
            st_nxt = UWC_ST_WAIT;
         end
         UWC_ST_WAIT: begin
            if (memWrAck) begin
               pend_nxt[memWrLvl_r] = 1'b0;
               pendEa_nxt[memWrLvl_r] = 1'b0;
               if ((pend_r & ~(3'h1 << memWrLvl_r)) == 3'h0) begin
                  commit = 1'b1;
                  st_nxt = UWC_ST_IDLE;
               end else begin
                  st_nxt = UWC_ST_UPD;
               end
            end
         end
         default: begin
            st_nxt = UWC_ST_IDLE;
         end
      endcase

      // Entry is built only after flags are set; no lower-level check
      if (commit) begin
         ent_nxt[victim] = fillTake ? newEnt : pendEnt_r;
         rr_nxt = rr_r + UWC_IDX_W'(1);
         fillDone_nxt = 1'b1;
         fillMade_nxt = 1'b1;
      end

      if (invTake) begin
         for (int i = 0; i < UWC_ENTRIES; i++) begin
            if (invMatch[i]) begin
               ent_nxt[i].valid = 1'b0;
            end
         end
         invAck_nxt = 1'b1;
      end

      fillReady_nxt = st_nxt == UWC_ST_IDLE && !fillTake;

      // Register port
      if (regWr) begin
         case (regAddr)
            UWC_REG_CFG: cfg_nxt = regWrData[13:0];
            UWC_REG_HITS: hits_nxt = 16'h0000;
            default: cfg_nxt = cfg_r;
         endcase
      end
      if (regRd) begin
         case (regAddr)
            UWC_REG_CFG: rdData_nxt = {18'h0, cfg_r};
            UWC_REG_STAT: begin
               for (int i = 0; i < UWC_ENTRIES; i++) begin
                  rdData_nxt[i] = ent_r[i].valid;
               end
               rdData_nxt[UWC_STAT_ST_LO +: 3] = st_r;
            end
            UWC_REG_HITS: rdData_nxt = {16'h0, hits_r};
            default: rdData_nxt = 32'h0;
         endcase
      end
   end

   // ==========================================================
   // Registers; entries change only by fill or invalidation
   always_ff @(posedge core_clk or negedge rstN) begin
      if (!rstN) begin
         for (int i = 0; i < UWC_ENTRIES; i++) begin
            ent_r[i] <= '0;
         end
         cfg_r <= UWC_CFG_RST;
         hits_r <= 16'h0000;
         rr_r <= '0;
         st_r <= UWC_ST_IDLE;
         pendEnt_r <= '0;
         pend_r <= 3'h0;
         pendEa_r <= 3'h0;
         regRdData_r <= 32'h0;
         lkRsp_r <= 1'b0;
         lkHit_r <= 1'b0;
         lkTable_r <= 40'h0;
         lkRd_r <= 1'b0;
         lkWr_r <= 1'b0;
         lkUs_r <= 1'b0;
         lkXd_r <= 1'b0;
         fillReady_r <= 1'b0;
         fillDone_r <= 1'b0;
         fillMade_r <= 1'b0;
         memWrReq_r <= 1'b0;
         memWrLvl_r <= 2'h0;
         memWrEa_r <= 1'b0;
         invAck_r <= 1'b0;
      end else begin
         ent_r <= ent_nxt;
         cfg_r <= cfg_nxt;
         hits_r <= hits_nxt;
         rr_r <= rr_nxt;
         st_r <= st_nxt;
         pendEnt_r <= pendEnt_nxt;
         pend_r <= pend_nxt;
         pendEa_r <= pendEa_nxt;
         regRdData_r <= rdData_nxt;
         lkRsp_r <= lkRsp_nxt;
         lkHit_r <= lkHit_nxt;
         lkTable_r <= lkTable_nxt;
         lkRd_r <= lkRd_nxt;
         lkWr_r <= lkWr_nxt;
         lkUs_r <= lkUs_nxt;
         lkXd_r <= lkXd_nxt;
         fillReady_r <= fillReady_nxt;
         fillDone_r <= fillDone_nxt;
         fillMade_r <= fillMade_nxt;
         memWrReq_r <= memWrReq_nxt;
         memWrLvl_r <= memWrLvl_nxt;
         memWrEa_r <= memWrEa_nxt;
         invAck_r <= invAck_nxt;
      end
   end

endmodule

`default_nettype wire

/* tb/uwc_walk_cache_props.sv */
// Port checker for the walk cache, bound from the bench top.
// Assumes the single clock core_clk and the low-active reset nrst.
`timescale 1ns/1ps
`default_nettype none
module uwc_walk_cache_props (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic lkReq,
   input wire logic lkRsp_r,
   input wire logic lkHit_r,
   input wire logic [39:0] lkTable_r,
   input wire logic fillReq,
   input wire logic [1:0] fillXlat,
   input wire logic fillLeaf,
   input wire logic [2:0] entPresent,
   input wire logic fillReady_r,
   input wire logic fillDone_r,
   input wire logic fillMade_r,
   input wire logic memWrReq_r,
   input wire logic memWrAck,
   input wire logic invReq,
   input wire logic invGlobal,
   input wire logic invAck_r
);
   // ==========================================================
   // Properties
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);
   wire fillTake = fillReq && fillReady_r;

   lk_answer_a:
      assert property (lkReq |=> lkRsp_r) else $error("lookup unanswered");
   miss_clean_a:
      assert property (lkRsp_r && !lkHit_r |-> lkTable_r == 40'h0)
      else $error("miss carries data");
   leaf_refused_a:
      assert property (fillTake && fillLeaf |=> fillDone_r && !fillMade_r)
      else $error("page leaf cached");
   absent_refused_a:
      assert property (fillTake && fillXlat != 2'h1 && !entPresent[1]
         |=> fillDone_r && !fillMade_r) else $error("absent entry cached");
   flag_first_a:
      assert property (memWrReq_r |-> (!fillDone_r) [*2])
      else $error("fill ended before flag write");
   wr_wait_a:
      assert property (memWrReq_r |=> (!memWrReq_r until memWrAck))
      else $error("flag write overlaps previous");
   fill_bound_a:
      assert property (fillTake |-> ##[1:100] fillDone_r)
      else $error("fill never ended");
   inv_bound_a:
      assert property ($rose(invReq) |-> ##[1:200] invAck_r)
      else $error("invalidation never acknowledged");
   inv_clear_a:
      assert property (invAck_r && invGlobal && lkReq |=> !lkHit_r)
      else $error("hit after global invalidation");
   inv_cause_a:
      assert property (invAck_r |-> $past(invReq) && !$past(invAck_r))
      else $error("acknowledge without request");
endmodule
`default_nettype wire

/* tb/uwc_mem_model.sv */
// Table memory answering accessed-flag writes of the walk cache.
// Assumes one write outstanding at a time; slow adds five cycles.
`timescale 1ns/1ps
`default_nettype none
module uwc_mem_model (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic memWrReq_r,
   input wire logic slow,
   output logic memWrAck
);
   // ==========================================================
   // Responder
   logic busy_r;
   logic [2:0] wait_r;
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         busy_r <= 1'b0;
         wait_r <= 3'h0;
         memWrAck <= 1'b0;
      end else begin
         memWrAck <= 1'b0;
         if (memWrReq_r) begin
            busy_r <= 1'b1;
            wait_r <= slow ? 3'h5 : 3'h0;
         end else if (busy_r && wait_r == 3'h0) begin
            busy_r <= 1'b0;
            memWrAck <= 1'b1;
         end else if (busy_r) begin
            wait_r <= wait_r - 3'h1;
         end
      end
   end
endmodule
`default_nettype wire

/* tb/upper_level_walk_cache_tb.sv */
// Self-checking bench: register, fill, lookup and invalidation traffic.
// Assumes the memory responder model; random values from a fixed LFSR.
`timescale 1ns/1ps
`default_nettype none
module upper_level_walk_cache_tb
   import uwc_pkg::*;
();
   // ==========================================================
   // Stimulus and observed signals
   logic core_clk = 1'b0, nrst = 1'b0, slow = 1'b0, memWrAck;
   logic regWr = 1'b0, regRd = 1'b0, lkReq = 1'b0, lkLvl4 = 1'b0;
   logic [7:0] regAddr = 8'h00;
   logic [31:0] regWrData = 32'h0, regRdData_r, lfsrState = 32'h1001E;
   logic [1:0] lkXlat = 2'h0, fillXlat = 2'h0, memWrLvl_r;
   logic [56:0] lkAddr = 57'h0, fillAddr = 57'h0;
   logic [15:0] lkDid = 16'h0, fillDid = 16'h0, invDid = 16'h0;
   logic lkPasidVld = 1'b0, fillPasidVld = 1'b0, fillReq = 1'b0;
   logic [19:0] lkPasid = 20'h0, fillPasid = 20'h0;
   logic [39:0] fillTable = 40'h0, lkTable_r;
   logic fillLvl4 = 1'b0, fillLeaf = 1'b0, invReq = 1'b0, invGlobal = 1'b0;
   logic [2:0] entPresent = 3'h7, entRsvdOk = 3'h7, entR = 3'h7;
   logic [2:0] entW = 3'h7, entU = 3'h7, entX = 3'h0, entAcc = 3'h7;
   logic [2:0] entExtAcc = 3'h7, nestRd = 3'h7, nestWr = 3'h7;
   logic [2:0] nestX = 3'h7, nestLocWr = 3'h7, needV;
   logic lkRsp_r, lkHit_r, lkRd_r, lkWr_r, lkUs_r, lkXd_r, invAck_r;
   logic fillReady_r, fillDone_r, fillMade_r, memWrReq_r, memWrEa_r;
   logic five = 1'b0, xdEn = 1'b0, ssxEn = 1'b0, eaEn = 1'b0, cmCap = 1'b0;
   logic [4:0] expFill;
   int mismatches = 0, checks = 0, hitCount = 0;

   always #2 core_clk = ~core_clk;

   // Every port has a bench signal of the same name
   uwc_walk_cache i_uwc_walk_cache (.*);
   uwc_mem_model i_uwc_mem_model (.*);

   // ==========================================================
   // Helpers
   function automatic logic [31:0] rnd();
      repeat (32) lfsrState = {lfsrState[30:0], ^(lfsrState & 32'h80200003)};
      return lfsrState;
   endfunction

   // Returns {made, rd, wr, us, xd}; also leaves the flag-write mask
   function automatic logic [4:0] expect_fill();
      logic [2:0] m;
      logic t, fs, aw, au, fx;
      logic [4:0] e;
      m = {five, 1'b1, !fillLvl4};
      needV = m & (~entAcc | ({3{eaEn}} & ~entExtAcc));
      t = fillLvl4;
      aw = &(entW | ~m);
      au = &(entU | ~m);
      fx = xdEn & |(entX & m);
      fs = (entPresent & entRsvdOk & m) == m;
      if (fillXlat == 2'h0) begin
         e = {fs, 1'b1, aw, au, fx};
      end else if (fillXlat == 2'h2) begin
         e = {fs && (nestRd & m) == m && (nestLocWr & needV) == needV,
            1'b1, aw & nestWr[t], au, fx | (ssxEn & !nestX[t])};
      end else begin
         e = {cmCap || ((entR | entW) & entRsvdOk & m) == m, &(entR | ~m),
            aw, 1'b1, ssxEn & !(&(entX | ~m))};
      end
      e[4] = e[4] && !fillLeaf;
      return e;
   endfunction

   task automatic check(input string what, input logic [63:0] seen,
      input logic [63:0] expv);
      checks++;
      if (seen !== expv) begin
         mismatches++;
         $display("wrong value %s: expected %0h, seen %0h", what, expv, seen);
      end
   endtask

   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      regAddr <= a;
      regWrData <= d;
      regWr <= 1'b1;
      @(posedge core_clk);
      regWr <= 1'b0;
   endtask

   task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge core_clk);
      regRd <= 1'b0;
      @(posedge core_clk);
      d = regRdData_r;
   endtask

   task automatic lookup(input logic [56:0] a, input logic [15:0] did,
      input logic [4:0] e);
      lkReq <= 1'b1;
      lkAddr <= a;
      lkDid <= did;
      lkLvl4 <= fillLvl4;
      lkXlat <= fillXlat;
      lkPasidVld <= fillPasidVld;
      lkPasid <= fillPasid;
      @(posedge core_clk);
      lkReq <= 1'b0;
      @(posedge core_clk);
      hitCount += e[4];
      check("lookup", {lkRsp_r, lkHit_r, lkTable_r, lkRd_r, lkWr_r, lkUs_r,
         lkXd_r}, {1'b1, e[4], e[4] ? {fillTable, e[3:0]} : 44'h0});
   endtask

   task automatic fill();
      logic [2:0] pend;
      logic [1:0] lv;
      logic watch;
      int n;
      expFill = expect_fill();
      watch = expFill[4] || fillXlat != 2'h2;
      pend = (expFill[4] && fillXlat != 2'h1) ? needV : 3'h0;
      fillReq <= 1'b1;
      n = 0;
      do @(posedge core_clk); while (fillReady_r !== 1'b1 && ++n < 50);
      fillReq <= 1'b0;
      n = 0;
      do begin
         @(posedge core_clk);
         if (memWrReq_r === 1'b1 && watch) begin
            lv = pend[2] ? 2'h2 : (pend[1] ? 2'h1 : 2'h0);
            check("flag write", {pend != 3'h0, memWrLvl_r}, {1'b1, lv});
            if (!entExtAcc[lv]) check("ext flag", memWrEa_r, eaEn);
            pend[lv] = 1'b0;
         end
      end while (fillDone_r !== 1'b1 && ++n < 100);
      check("fill", {fillDone_r, fillMade_r}, {1'b1, expFill[4]});
      if (watch) check("writes left", pend, 3'h0);
   endtask

   task automatic inval(input logic g, input logic [15:0] did,
      input logic probe);
      int n;
      invReq <= 1'b1;
      invGlobal <= g;
      invDid <= did;
      lkReq <= probe;
      n = 0;
      do @(posedge core_clk); while (invAck_r !== 1'b1 && ++n < 100);
      invReq <= 1'b0;
      lkReq <= 1'b0;
      check("inv ack", invAck_r, 1'b1);
      @(posedge core_clk);
   endtask

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // ==========================================================
   // Sequence
   // Each entry: {level4, five-level, hit expected, flipped address bit}
   logic [8:0] tagCases [6] = '{9'h05D, 9'h01E, 9'h02F, 9'h166, 9'h127,
      9'h0B8};

   initial begin
      logic [31:0] d, r, q;
      logic [63:0] a;
      repeat (12) @(posedge core_clk);
      nrst <= 1'b1;
      repeat (4) @(posedge core_clk);
      reg_rd(UWC_REG_CFG, d);
      check("config", d, 32'h2F00);
      reg_rd(UWC_REG_STAT, d);
      check("status", d, 32'h10000);
      reg_wr(8'h0C, 32'hFFFFFFFF);
      reg_rd(8'h0C, d);
      check("unmapped", d, 32'h0);
      a = {rnd(), rnd()};
      fillAddr <= a[56:0];
      fillDid <= 16'h0042;
      foreach (tagCases[i]) begin
         fillLvl4 <= tagCases[i][8];
         five = tagCases[i][7];
         reg_wr(UWC_REG_CFG, {18'h0, 6'h2F, 7'h0, five});
         fill();
         lookup(fillAddr ^ (57'h1 << tagCases[i][5:0]), fillDid,
            tagCases[i][6] ? expFill : 5'h0);
      end
      lookup(fillAddr, fillDid ^ 16'h1, 5'h0);
      inval(1'b0, fillDid ^ 16'h1, 1'b0);
      lookup(fillAddr, fillDid, expFill);
      inval(1'b0, fillDid, 1'b0);
      lookup(fillAddr, fillDid, 5'h0);
      fill();
      inval(1'b1, 16'h0, 1'b1);
      reg_wr(UWC_REG_HITS, 32'h0);
      hitCount = 0;
      repeat (40) begin
         r = rnd();
         q = rnd();
         a = {rnd(), rnd()};
         {cmCap, eaEn, ssxEn, xdEn, five} = r[31:27];
         reg_wr(UWC_REG_CFG, {18'h0, 6'h2F, 3'h0, r[31:27]});
         inval(1'b1, 16'h0, 1'b0);
         reg_rd(UWC_REG_STAT, d);
         check("status", d, 32'h10000);
         entPresent <= r[2:0] | q[2:0];
         entRsvdOk <= r[5:3] | q[5:3];
         nestRd <= r[8:6] | q[8:6];
         nestLocWr <= r[11:9] | q[11:9];
         {entR, entW, entU, entX, entAcc} <= r[26:12];
         {nestX, nestWr, entExtAcc} <= q[20:12] | {3'h0, q[2:0], 3'h0};
         fillLeaf <= &q[23:21];
         fillLvl4 <= q[24];
         fillXlat <= (q[26:25] == 2'h3) ? 2'h0 : q[26:25];
         slow <= q[27];
         fillPasidVld <= q[28];
         fillAddr <= a[56:0];
         fillDid <= a[63:48];
         fillPasid <= a[19:0];
         fillTable <= {r[7:0], q};
         @(posedge core_clk);
         fill();
         lookup(fillAddr, fillDid, expFill);
      end
      reg_rd(UWC_REG_HITS, d);
      check("hits", d, hitCount);
      give_verdict();
   end

   initial begin
      #200000;
      mismatches++;
      give_verdict();
   end
endmodule

bind uwc_walk_cache uwc_walk_cache_props i_uwc_walk_cache_props (.*);
`default_nettype wire
